// [src/i2c_port_slave.sv]
/*
 Register port of the charger: a two-wire slave at a fixed address with a
 register pointer, burst write and burst read. Registers are plain storage
 here; the charger logic reads them through a flat output.
 Assumes a master on the far side of the carrier and a rail-low indication.
*/
`include "i2c_port_defines.svh"
// Functional notes
// R1: Slave only, standard and fast rates
// R2: SDA changes only while SCL low
// R3: Detect START and STOP while SCL high
// R4: Master alone makes START and STOP
// R5: Eight bits, MSB first, then ack
// R6: May stretch SCL low between bytes
// R7: Transmitter releases SDA on ninth clock
// R8: Ack holds SDA low whole high phase
// R9: SDA high on ninth clock means NACK
// R10: Ack write address and data; read address only
// R11: Master sends address, register, then data
// R12: Commit data byte right after its ack
// R13: Pointer advances after each data ack
// R14: Read uses register write then repeated START
// R15: Send pointer byte; advance on master ack
// R16: NACK or STOP ends the read
// R17: Pointer kept across STOP for split reads
// R18: Respond only to address 0x92/0x93
// R19: Rail undervoltage clears all port registers
// R20: Out-of-range register address not acknowledged
// R21: Synchronise SCL, SDA and find their edges
module i2c_port_slave
	import i2c_port_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic enable_in,
	i2c_port_if.slave bus,
	input wire logic rail_uv_in,
	input wire logic hold_in,
	output logic [111:0] regs_out,
	output logic wr_strobe_out,
	output logic [7:0] wr_index_out
);
	// ============================================================
	// Synchronisers and edge detection
	logic [1:0] scl_sync_r, sda_sync_r, uv_sync_r, hold_sync_r;
	logic scl_d_r, sda_d_r;
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			uv_sync_r <= 2'h0;
			hold_sync_r <= 2'h0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else if (enable_in) begin
			scl_sync_r <= {scl_sync_r[0], bus.scl}; // R21
			sda_sync_r <= {sda_sync_r[0], bus.sda}; // R21
			uv_sync_r <= {uv_sync_r[0], rail_uv_in};
			hold_sync_r <= {hold_sync_r[0], hold_in};
			scl_d_r <= scl_sync_r[1];
			sda_d_r <= sda_sync_r[1];
		end
	end
	wire scl_s = scl_sync_r[1];
	wire sda_s = sda_sync_r[1];
	wire scl_rise = scl_s & ~scl_d_r; // R1 R21
	wire scl_fall = ~scl_s & scl_d_r; // R21
	wire start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s; // R3
	wire stop_seen = scl_s & scl_d_r & ~sda_d_r & sda_s; // R3
	wire uv = uv_sync_r[1];

	function automatic logic in_range(input byte_t idx);
		in_range = (idx <= `REG_LAST);
	endfunction

	// ============================================================
	// Protocol engine and register file
	slave_state_t st_r, st_nxt;
	byte_t regs_r [0:13];
	byte_t sh_r, sh_nxt, ptr_r, ptr_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic first_r, first_nxt, ackd_r, ackd_nxt, sda_r, sda_nxt;
	logic scl_r, scl_nxt, wr_r, wr_nxt;
	byte_t wri_r, wri_nxt;

	// Pointers past the last register read as zero
	function automatic byte_t reg_at(input byte_t idx);
		reg_at = in_range(idx) ? regs_r[idx[3:0]] : 8'h00;
	endfunction

	always_comb begin
		st_nxt = st_r;
		sh_nxt = sh_r;
		ptr_nxt = ptr_r;
		bit_nxt = bit_r;
		first_nxt = first_r;
		ackd_nxt = ackd_r;
		sda_nxt = sda_r;
		scl_nxt = scl_r;
		wr_nxt = 1'b0;
		wri_nxt = wri_r;
		if (start_seen) begin
			st_nxt = SL_ADDR; // R3
			bit_nxt = 4'h0;
			sda_nxt = 1'b1;
		end else if (stop_seen) begin
			st_nxt = SL_IDLE; // R16 R17
			sda_nxt = 1'b1;
		end else begin
			case (st_r)
				SL_IDLE: begin
					sda_nxt = 1'b1;
				end
				SL_ADDR, SL_RX: begin
					if (scl_rise) begin
						sh_nxt = {sh_r[6:0], sda_s}; // R5
						bit_nxt = bit_r + 4'h1;
					end
					if (scl_fall && bit_r == `BYTE_BITS) begin
						bit_nxt = 4'h0;
						if (st_r == SL_ADDR) begin
							if (sh_r[7:1] == `SLAVE_ADDR7) begin // R18
								sda_nxt = 1'b0; // R8 R10
								st_nxt = SL_AACK;
								first_nxt = ~sh_r[0];
							end else begin
								st_nxt = SL_IDLE;
							end
						end else if (first_r) begin
							ackd_nxt = in_range(sh_r); // R20
							sda_nxt = ~in_range(sh_r); // R20
							st_nxt = SL_RACK;
						end else begin
							ackd_nxt = in_range(ptr_r);
							sda_nxt = ~in_range(ptr_r); // R10
							st_nxt = SL_RACK;
						end
					end
				end
				SL_AACK: begin
					if (scl_fall) begin
						if (sh_r[0]) begin
							{sda_nxt, sh_nxt} = {reg_at(ptr_r), 1'b1}; // R15
							bit_nxt = 4'h1;
							st_nxt = SL_TX;
							scl_nxt = ~hold_sync_r[1]; // R6
						end else begin
							sda_nxt = 1'b1;
							st_nxt = SL_RX;
						end
					end
				end
				SL_RACK: begin
					if (scl_fall) begin
						sda_nxt = 1'b1;
						st_nxt = ackd_r ? SL_RX : SL_IDLE; // R9
						if (ackd_r && first_r) begin
							ptr_nxt = sh_r; // R11 R14 R17
							first_nxt = 1'b0;
						end else if (ackd_r) begin
							wr_nxt = 1'b1; // R12
							wri_nxt = ptr_r;
							ptr_nxt = ptr_r + 8'h01; // R13
						end
					end
				end
				SL_TX: begin
					if (!scl_r) begin
						scl_nxt = ~hold_sync_r[1]; // R6
					end else if (scl_fall) begin
						if (bit_r == `BYTE_BITS) begin
							sda_nxt = 1'b1; // R7 R10
							st_nxt = SL_TACK;
						end else begin
							sda_nxt = sh_r[7]; // R2 R5
							sh_nxt = {sh_r[6:0], 1'b1};
							bit_nxt = bit_r + 4'h1;
						end
					end
				end
				SL_TACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							st_nxt = SL_IDLE; // R9 R16
						end else begin
							ptr_nxt = ptr_r + 8'h01; // R15
						end
					end else if (scl_fall) begin
						{sda_nxt, sh_nxt} = {reg_at(ptr_r), 1'b1}; // R15
						bit_nxt = 4'h1;
						st_nxt = SL_TX;
						scl_nxt = ~hold_sync_r[1]; // R6
					end
				end
				default: begin
					st_nxt = SL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in || (enable_in && uv)) begin // R19
			st_r <= SL_IDLE;
			sh_r <= 8'h00;
			ptr_r <= 8'h00;
			bit_r <= 4'h0;
			first_r <= 1'b0;
			ackd_r <= 1'b0;
			sda_r <= 1'b1;
			scl_r <= 1'b1;
			wr_r <= 1'b0;
			wri_r <= 8'h00;
			for (int i = 0; i < 14; i++) begin
				regs_r[i] <= 8'h00; // R19
			end
		end else if (enable_in) begin
			st_r <= st_nxt;
			sh_r <= sh_nxt;
			ptr_r <= ptr_nxt;
			bit_r <= bit_nxt;
			first_r <= first_nxt;
			ackd_r <= ackd_nxt;
			sda_r <= sda_nxt;
			scl_r <= scl_nxt;
			wr_r <= wr_nxt;
			wri_r <= wri_nxt;
			if (wr_nxt) begin
				regs_r[ptr_r[3:0]] <= sh_r; // R12
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 14; i++) begin
			regs_out[i*8 +: 8] = regs_r[i];
		end
	end

	assign bus.sda_oe_s_n = sda_r;
	assign bus.scl_oe_s_n = scl_r;
	assign wr_strobe_out = wr_r;
	assign wr_index_out = wri_r;
endmodule

// [src/i2c_port_defines.svh]
/*
 Holds the timing counts, bus address and register-range constants for the
 two-wire register port and its master end. Assumes inclusion by bare name.
*/
`ifndef I2C_PORT_DEFINES_SVH
`define I2C_PORT_DEFINES_SVH

`define SYS_CLK_PERIOD_NS 5
`define SLAVE_ADDR7 7'h49
`define ADDR_BYTE_WRITE 8'h92
`define ADDR_BYTE_READ 8'h93
`define REG_COUNT 8'h0e
`define REG_LAST 8'h0d
`define BYTE_BITS 4'h8
`define STD_RATE_KBPS 100
`define FAST_RATE_KBPS 400
`define SCL_HALF_NS 1250
`define SCL_HALF_CYCLES ((`SCL_HALF_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define STRETCH_CYCLES 4

`endif

// [src/i2c_port_pkg.sv]
/*
 Holds the shared types of the register port and its master end.
 Assumes the defines header is compiled alongside.
*/
package i2c_port_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [6:0] {
		SL_IDLE = 7'b0000001,
		SL_ADDR = 7'b0000010,
		SL_AACK = 7'b0000100,
		SL_RX = 7'b0001000,
		SL_RACK = 7'b0010000,
		SL_TX = 7'b0100000,
		SL_TACK = 7'b1000000
	} slave_state_t;
	typedef enum logic [7:0] {
		MS_IDLE = 8'b00000001,
		MS_START = 8'b00000010,
		MS_BIT_LO = 8'b00000100,
		MS_BIT_HI = 8'b00001000,
		MS_STOP_LO = 8'b00010000,
		MS_STOP_HI = 8'b00100000,
		MS_STOP_END = 8'b01000000,
		MS_DONE = 8'b10000000
	} master_state_t;
endpackage

// [src/i2c_port_if.sv]
/*
 Two-wire bus carrier joining the master end and the register port.
 Resolves open-drain levels from the enables; enable low means pulling low.
*/
interface i2c_port_if;
	logic scl_oe_m_n;
	logic sda_oe_m_n;
	logic scl_oe_s_n;
	logic sda_oe_s_n;
	logic scl;
	logic sda;
	assign scl = scl_oe_m_n & scl_oe_s_n;
	assign sda = sda_oe_m_n & sda_oe_s_n;
	modport master (output scl_oe_m_n, output sda_oe_m_n, input scl, input sda);
	modport slave (output scl_oe_s_n, output sda_oe_s_n, input scl, input sda);
endinterface

// [src/i2c_port_master.sv]
/*
 Master end: sends one byte per command, optionally preceded by START and
 followed by STOP, or receives one byte and acknowledges it or not.
 Assumes the register port on the far side of the carrier.
*/
`include "i2c_port_defines.svh"
module i2c_port_master
	import i2c_port_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic enable_in,
	i2c_port_if.master bus,
	input wire logic cmd_valid_in,
	input wire logic cmd_start_in,
	input wire logic cmd_stop_in,
	input wire logic cmd_read_in,
	input wire logic cmd_ack_in,
	input wire logic [7:0] cmd_data_in,
	output logic busy_out,
	output logic done_out,
	output logic ack_seen_out,
	output logic [7:0] rd_data_out
);
	// ============================================================
	// Bus sampling
	logic [1:0] scl_sync_r, sda_sync_r;
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
		end else if (enable_in) begin
			scl_sync_r <= {scl_sync_r[0], bus.scl};
			sda_sync_r <= {sda_sync_r[0], bus.sda};
		end
	end
	wire scl_s = scl_sync_r[1];
	wire sda_s = sda_sync_r[1];

	// ============================================================
	// Sequencer
	master_state_t st_r, st_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [8:0] sh_r, sh_nxt;
	logic scl_r, scl_nxt, sda_r, sda_nxt;
	logic stop_r, stop_nxt, rd_r, rd_nxt;
	logic done_r, done_nxt, ack_r, ack_nxt;
	logic [7:0] rdd_r, rdd_nxt;
	logic busy_r, busy_nxt;
	logic timeup;
	assign timeup = (cnt_r == 16'(`SCL_HALF_CYCLES));

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = timeup ? 16'h0000 : cnt_r + 16'h0001;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		scl_nxt = scl_r;
		sda_nxt = sda_r;
		stop_nxt = stop_r;
		rd_nxt = rd_r;
		done_nxt = 1'b0;
		ack_nxt = ack_r;
		rdd_nxt = rdd_r;
		case (st_r)
			MS_IDLE: begin
				cnt_nxt = 16'h0000;
				if (cmd_valid_in) begin
					stop_nxt = cmd_stop_in;
					rd_nxt = cmd_read_in;
					bit_nxt = 4'h0;
					// Read byte: release SDA for data, then drive our ack bit
					sh_nxt = cmd_read_in ? {8'hff, ~cmd_ack_in} : {cmd_data_in, 1'b1}; // R5 R7
					if (cmd_start_in) begin
						// Release SDA while SCL may still be low
						sda_nxt = 1'b1;
						st_nxt = MS_START;
					end else begin
						st_nxt = MS_BIT_LO;
					end
				end
			end
			MS_START: begin
				// Repeated START first raises SCL, then SDA falls while high
				if (timeup) begin
					if (!scl_r) begin
						scl_nxt = 1'b1; // R2
					end else if (sda_r) begin
						sda_nxt = 1'b0; // R4
					end else begin
						scl_nxt = 1'b0;
						st_nxt = MS_BIT_LO;
					end
				end
			end
			MS_BIT_LO: begin
				if (timeup) begin
					sda_nxt = sh_r[8]; // R2
					scl_nxt = 1'b1;
					st_nxt = MS_BIT_HI;
				end else begin
					scl_nxt = 1'b0;
					if (cnt_r == 16'h0001) begin
						sda_nxt = sh_r[8]; // R2
					end
				end
			end
			MS_BIT_HI: begin
				// Hold while a slave stretches the clock
				if (!scl_s) begin
					cnt_nxt = 16'h0000; // R6
				end else if (timeup) begin
					scl_nxt = 1'b0;
					sh_nxt = {sh_r[7:0], sda_s};
					bit_nxt = bit_r + 4'h1;
					if (bit_r == `BYTE_BITS) begin
						ack_nxt = ~sda_s; // R9
						if (rd_r) begin
							rdd_nxt = sh_r[7:0];
						end
						st_nxt = stop_r ? MS_STOP_LO : MS_DONE;
					end else begin
						st_nxt = MS_BIT_LO;
					end
				end
			end
			MS_STOP_LO: begin
				scl_nxt = 1'b0;
				if (timeup) begin
					sda_nxt = 1'b0;
					st_nxt = MS_STOP_HI;
				end
			end
			MS_STOP_HI: begin
				if (timeup) begin
					scl_nxt = 1'b1;
					st_nxt = MS_STOP_END;
				end
			end
			MS_STOP_END: begin
				if (timeup) begin
					sda_nxt = 1'b1; // R4
					st_nxt = MS_DONE;
				end
			end
			MS_DONE: begin
				done_nxt = 1'b1;
				st_nxt = MS_IDLE;
			end
			default: begin
				st_nxt = MS_IDLE;
			end
		endcase
		busy_nxt = (st_nxt != MS_IDLE);
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			st_r <= MS_IDLE;
			cnt_r <= 16'h0000;
			bit_r <= 4'h0;
			sh_r <= 9'h1ff;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			stop_r <= 1'b0;
			rd_r <= 1'b0;
			done_r <= 1'b0;
			ack_r <= 1'b0;
			rdd_r <= 8'h00;
			busy_r <= 1'b0;
		end else if (enable_in) begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			scl_r <= scl_nxt;
			sda_r <= sda_nxt;
			stop_r <= stop_nxt;
			rd_r <= rd_nxt;
			done_r <= done_nxt;
			ack_r <= ack_nxt;
			rdd_r <= rdd_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign bus.scl_oe_m_n = scl_r;
	assign bus.sda_oe_m_n = sda_r;
	assign busy_out = busy_r;
	assign done_out = done_r;
	assign ack_seen_out = ack_r;
	assign rd_data_out = rdd_r;
endmodule

// [verification/i2c_port_monitor.sv]
/*
 Bus-level checks of the two-wire link between master end and register port.
 Assumes the carrier's resolved wires and enables, sampled by clock_in.
*/
module i2c_port_monitor (
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic scl_oe_m_n,
	input wire logic sda_oe_m_n,
	input wire logic scl_oe_s_n,
	input wire logic sda_oe_s_n,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================
	// Bit and byte tracking
	logic scl_r, sda_r, first_r, rd_r, first_nxt, rd_nxt, rise, start;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	assign rise = scl && !scl_r;
	assign start = scl && scl_r && sda_r && !sda;
	always_comb begin
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		first_nxt = first_r;
		rd_nxt = rd_r;
		if (start) begin
			cnt_nxt = 4'h0;
			first_nxt = 1'b1;
			rd_nxt = 1'b0;
		end else if (rise) begin
			cnt_nxt = (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
			if (cnt_r != 4'h8) shift_nxt = {shift_r[6:0], sda};
			if (cnt_r == 4'h8 && first_r) begin
				first_nxt = 1'b0;
				rd_nxt = shift_r[0];
			end
		end
	end
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			first_r <= 1'b0;
			rd_r <= 1'b0;
		end else begin
			scl_r <= scl;
			sda_r <= sda;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			first_r <= first_nxt;
			rd_r <= rd_nxt;
		end
	end
	// ==========================================
	// Assertions
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (reset_in);
	sequence ack_held;
		(!sda_oe_s_n && scl) [*8];
	endsequence
	data_stable_a: assert property ($changed(sda_oe_s_n) |-> !scl && !$past(scl))
		else $error("slave moved sda while scl high");
	ack_hold_a: assert property ($rose(scl) && !sda_oe_s_n |-> ack_held)
		else $error("slave low drive not held over high phase");
	slave_only_a: assert property (scl && scl_r && sda != sda_r |-> $changed(sda_oe_m_n))
		else $error("sda edge under high scl not from master");
	stretch_low_a: assert property ($fell(scl_oe_s_n) |-> !$past(scl))
		else $error("slave pulled scl during high phase");
	addr_match_a: assert property (rise && cnt_r == 4'h8 && first_r |->
		sda_oe_s_n == (shift_r[7:1] != 7'h49))
		else $error("address ack wrong");
	no_data_ack_a: assert property (rise && cnt_r == 4'h8 && !first_r && rd_r |-> sda_oe_s_n)
		else $error("slave acked its own data");
	tx_release_a: assert property (rise && cnt_r == 4'h8 && !rd_r |-> sda_oe_m_n)
		else $error("master held sda on ninth clock");
	recv_release_a: assert property (rise && cnt_r != 4'h8 && !rd_r |-> sda_oe_s_n)
		else $error("slave drove a data bit it receives");
endmodule

// [verification/charger_i2c_register_port_test.sv]
/*
 Self-checking bench: master end and register port across the carrier.
 Assumes package, carrier, design ends and monitor compiled before it.
*/
module test_charger_i2c_register_port import i2c_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock_in = 1'b0, reset_in = 1'b1, rail_uv_in = 1'b0, hold_in = 1'b0;
	logic cmd_valid_in = 1'b0, cmd_start_in = 1'b0, cmd_stop_in = 1'b0;
	logic cmd_read_in = 1'b0, cmd_ack_in = 1'b0;
	byte_t cmd_data_in = 8'h00;
	logic busy_out, done_out, ack_seen_out, wr_strobe_out;
	byte_t rd_data_out, wr_index_out, d0, d1;
	logic [111:0] regs_out;
	logic [9:0] byte_q[$];
	logic [15:0] write_q[$];
	logic [9:0] n;
	logic [15:0] w;
	int errors = 0;
	int checks = 0;
	integer seed = 32'h0fa19098;
	always #2.5 clock_in = ~clock_in;
	i2c_port_if i2c_port_if_i ();
	i2c_port_master i2c_port_master_i (.clock_in, .reset_in, .enable_in(1'b1),
		.bus(i2c_port_if_i), .cmd_valid_in, .cmd_start_in, .cmd_stop_in, .cmd_read_in,
		.cmd_ack_in, .cmd_data_in, .busy_out, .done_out, .ack_seen_out, .rd_data_out);
	i2c_port_slave i2c_port_slave_i (.clock_in, .reset_in, .enable_in(1'b1),
		.bus(i2c_port_if_i), .rail_uv_in, .hold_in, .regs_out, .wr_strobe_out,
		.wr_index_out);
	i2c_port_monitor i2c_port_monitor_i (.clock_in, .reset_in,
		.scl_oe_m_n(i2c_port_if_i.scl_oe_m_n), .sda_oe_m_n(i2c_port_if_i.sda_oe_m_n),
		.scl_oe_s_n(i2c_port_if_i.scl_oe_s_n), .sda_oe_s_n(i2c_port_if_i.sda_oe_s_n),
		.scl(i2c_port_if_i.scl), .sda(i2c_port_if_i.sda));
	// ==========================================
	// Reporting
	task automatic print_verdict();
		if (errors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_byte(input logic [8:0] got, input logic [8:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_write(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// ==========================================
	// Result watcher
	always begin
		@(posedge clock_in);
		#1;
		if (done_out === 1'b1) begin
			n = byte_q.size() ? byte_q.pop_front() : 10'h3ff;
			cmp_byte({ack_seen_out, n[9] ? rd_data_out : n[7:0]}, n[8:0]);
		end
		if (wr_strobe_out === 1'b1) begin
			w = write_q.size() ? write_q.pop_front() : 16'hffff;
			cmp_write({wr_index_out, regs_out[wr_index_out[3:0] * 8 +: 8]}, w);
		end
	end
	// ==========================================
	// One byte command: f is start, stop, read, ack
	task automatic op(input logic [3:0] f, input byte_t d, input logic ea, input byte_t ed);
		@(posedge clock_in);
		#1;
		{cmd_start_in, cmd_stop_in, cmd_read_in, cmd_ack_in} = f;
		cmd_data_in = d;
		cmd_valid_in = 1'b1;
		byte_q.push_back({f[1], ea, ed});
		@(posedge clock_in);
		#1 cmd_valid_in = 1'b0;
		cmp_flag(busy_out, 1'b1);
		for (int i = 0; i < 12000; i++) begin
			@(posedge clock_in);
			#1;
			if (done_out === 1'b1) begin
				cmp_flag(busy_out, 1'b0);
				return;
			end
		end
		errors++;
		print_verdict();
	endtask
	// ==========================================
	// Scenarios
	initial begin
		repeat (6) @(posedge clock_in);
		#1 reset_in = 1'b0;
		d0 = byte_t'($random(seed)) | 8'h01;
		d1 = byte_t'($random(seed)) | 8'h01;
		write_q.push_back({8'h0c, d0});
		write_q.push_back({8'h0d, d1});
		op(4'h8, 8'h92, 1'b1, 8'h00);
		op(4'h0, 8'h0c, 1'b1, 8'h00);
		op(4'h0, d0, 1'b1, 8'h00);
		op(4'h0, d1, 1'b1, 8'h00);
		op(4'h4, 8'h55, 1'b0, 8'h00);
		op(4'h8, 8'h92, 1'b1, 8'h00);
		op(4'h0, 8'h0c, 1'b1, 8'h00);
		op(4'h8, 8'h93, 1'b1, 8'h00);
		op(4'h3, 8'h00, 1'b1, d0);
		op(4'h6, 8'h00, 1'b0, d1);
		op(4'hc, 8'h90, 1'b0, 8'h00);
		op(4'h8, 8'h92, 1'b1, 8'h00);
		op(4'h4, 8'h0d, 1'b1, 8'h00);
		op(4'h8, 8'h92, 1'b1, 8'h00);
		op(4'h4, 8'h0e, 1'b0, 8'h00);
		hold_in = 1'b1;
		op(4'h8, 8'h93, 1'b1, 8'h00);
		fork
			op(4'h6, 8'h00, 1'b0, d1);
			begin
				repeat (2000) @(posedge clock_in);
				cmp_flag(i2c_port_if_i.scl_oe_s_n, 1'b0);
				cmp_flag(busy_out, 1'b1);
				#1 hold_in = 1'b0;
			end
		join
		rail_uv_in = 1'b1;
		repeat (10) @(posedge clock_in);
		#1 rail_uv_in = 1'b0;
		repeat (10) @(posedge clock_in);
		cmp_write(regs_out[111:96], 16'h0000);
		cmp_write(16'(byte_q.size() + write_q.size()), 16'h0000);
		print_verdict();
	end
endmodule
